// ---- pci_map.svh ----
`ifndef PCI_MAP_SVH
`define PCI_MAP_SVH

// Word indices on the register bus (byte address = 4 * index)
`define PCI_IDX_DIR     4'h0
`define PCI_IDX_OUT     4'h1
`define PCI_IDX_LEVEL   4'h2
`define PCI_IDX_RISE    4'h3
`define PCI_IDX_FALL    4'h4
`define PCI_IDX_FLAG    4'h5
`define PCI_IDX_PULLUP  4'h6
`define PCI_IDX_PULLDN  4'h7
`define PCI_IDX_PADCTL  4'h8
`define PCI_IDX_SUMMARY 4'h9
`define PCI_IDX_IRQSTAT 4'hA
`define PCI_IDX_IRQCLR  4'hB
`define PCI_IDX_IRQEN   4'hC

// Field positions
`define PCI_BIT_MASTER  15
`define PCI_BIT_GLOBAL  3
`define PCI_BIT_SUMMARY 0

// Reset values and the all-ones mask
`define PCI_RST_DIR     16'hFFFF
`define PCI_RST_ZERO    16'h0000
`define PCI_ONES        16'hFFFF

`endif

// ---- pci_pkg.sv ----
`default_nettype none
package pci_pkg;

   // Bus answer sequencer
   typedef enum logic {PCI_IDLE, PCI_ACK} pci_bus_state_t;

   // Pad controls that travel together to the I/O ring
   typedef struct packed {
      logic [15:0] oe;
      logic [15:0] out;
      logic [15:0] pull_up;
      logic [15:0] pull_dn;
   } pci_pad_t;

endpackage
`default_nettype wire

// ---- pci_port.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pci_map.svh"
// Contract
// - Rise enable catches low-to-high change
// - Fall enable catches high-to-low change
// - Both enables give two separate events
// - Detect only when enabled and flag clear
// - Change seen even without running clock
// - Enabled edge sets pin change flag
// - Flag clears by zero, one keeps
// - Summary bit set when any flag set
// - Summary clears itself, holds no state
// - New edge during clear keeps flag
// - Separate pull-up and pull-down per pin
// - Direction one input, zero output
// - Port read returns current pin level
module pci_port #(
   parameter int N_PINS = 16
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic [3:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic [15:0]       pin_in,
   output pci_pkg::pci_pad_t      pad_ctl,
   output logic                   irq
);

   // Byte enables to a 16-bit lane mask
   function automatic logic [15:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   // Merge write data into a register under the lane mask
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] wd,
                                         input logic [15:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   // Register lanes are 16 bits wide, so no other pin count fits
   if (N_PINS != 16) begin : g_bad_pins
      $error("pin count must be 16");
   end

   pci_pkg::pci_bus_state_t state_ff;
   pci_pkg::pci_bus_state_t nxt_state;
   pci_pkg::pci_pad_t       pad_ff;
   pci_pkg::pci_pad_t       nxt_pad;
   logic [15:0] dir_ff;
   logic [15:0] rise_ff;
   logic [15:0] fall_ff;
   logic [15:0] flag_ff;
   logic [15:0] prev_ff;
   logic        master_ff;
   logic        ien_ff;
   logic        ist_ff;
   logic        irq_ff;
   logic        wait_ff;
   logic [31:0] rdata_ff;
   logic [15:0] nxt_dir;
   logic [15:0] nxt_rise;
   logic [15:0] nxt_fall;
   logic [15:0] nxt_flag;
   logic        nxt_master;
   logic        nxt_ien;
   logic        nxt_ist;
   logic        nxt_irq;
   logic        nxt_wait;
   logic [31:0] nxt_rdata;

   // Bus decode: a write lands only at the edge where waitrequest is low
   wire         req     = avs_read | avs_write;
   wire         wr_go   = ce & (state_ff == pci_pkg::PCI_ACK) & avs_write;
   wire [15:0]  wmask   = lane_mask(avs_byteenable);
   wire [15:0]  wd      = avs_writedata[15:0];
   wire         hit_dir = wr_go & (avs_address == `PCI_IDX_DIR);
   wire         hit_out = wr_go & (avs_address == `PCI_IDX_OUT);
   wire         hit_ris = wr_go & (avs_address == `PCI_IDX_RISE);
   wire         hit_fal = wr_go & (avs_address == `PCI_IDX_FALL);
   wire         hit_flg = wr_go & (avs_address == `PCI_IDX_FLAG);
   wire         hit_pu  = wr_go & (avs_address == `PCI_IDX_PULLUP);
   wire         hit_pd  = wr_go & (avs_address == `PCI_IDX_PULLDN);
   wire         hit_pad = wr_go & (avs_address == `PCI_IDX_PADCTL);
   wire         hit_clr = wr_go & (avs_address == `PCI_IDX_IRQCLR);
   wire         hit_ien = wr_go & (avs_address == `PCI_IDX_IRQEN);

   // detection gate
   // Global enable, master enable and a clear interrupt flag together
   wire         gate_w  = ien_ff & master_ff & ~ist_ff;

   // compare with last seen level
   // Levels are compared with the last seen level, not a fixed clock
   // window, so a change made while ce is low still shows on wake-up.
   // rising edge hit
   wire [15:0]  rise_hit = rise_ff & pin_in & ~prev_ff;
   wire [15:0]  fall_hit = fall_ff & ~pin_in & prev_ff;
   wire [15:0]  evt      = (rise_hit | fall_hit) & {16{gate_w}};
   // Pins watching both edges; each change counts on its own
   wire [15:0]  both_hit = rise_ff & fall_ff & (pin_in ^ prev_ff);

   wire [15:0]  keep     = hit_flg ? (wd | ~wmask) : `PCI_ONES;
   assign nxt_flag = (flag_ff & keep) | evt;

   // no stored summary bit
   // Derived live from the flags so it can never go stale.
   wire         summary = |flag_ff;

   wire         ist_set = summary & master_ff;
   assign nxt_ist = (ist_ff & ~(hit_clr & wmask[`PCI_BIT_GLOBAL]
                                & wd[`PCI_BIT_GLOBAL])) | ist_set;
   assign nxt_ien = (hit_ien & wmask[`PCI_BIT_GLOBAL])
                    ? wd[`PCI_BIT_GLOBAL] : ien_ff;
   assign nxt_irq = nxt_ist & nxt_ien;

   // Plain control registers
   assign nxt_dir    = hit_dir ? merge(dir_ff, wd, wmask) : dir_ff;
   assign nxt_rise   = hit_ris ? merge(rise_ff, wd, wmask) : rise_ff;
   assign nxt_fall   = hit_fal ? merge(fall_ff, wd, wmask) : fall_ff;
   assign nxt_master = (hit_pad & wmask[`PCI_BIT_MASTER])
                       ? wd[`PCI_BIT_MASTER] : master_ff;

   assign nxt_pad.oe      = ~nxt_dir;
   assign nxt_pad.out     = hit_out ? merge(pad_ff.out, wd, wmask)
                                    : pad_ff.out;
   assign nxt_pad.pull_up = hit_pu ? merge(pad_ff.pull_up, wd, wmask)
                                   : pad_ff.pull_up;
   assign nxt_pad.pull_dn = hit_pd ? merge(pad_ff.pull_dn, wd, wmask)
                                   : pad_ff.pull_dn;

   // Read mux; unmapped words read as zero
   wire [15:0] rd16 =
      (avs_address == `PCI_IDX_DIR)     ? dir_ff :
      (avs_address == `PCI_IDX_OUT)     ? pad_ff.out :
      (avs_address == `PCI_IDX_LEVEL)   ? pin_in :
      (avs_address == `PCI_IDX_RISE)    ? rise_ff :
      (avs_address == `PCI_IDX_FALL)    ? fall_ff :
      (avs_address == `PCI_IDX_FLAG)    ? flag_ff :
      (avs_address == `PCI_IDX_PULLUP)  ? pad_ff.pull_up :
      (avs_address == `PCI_IDX_PULLDN)  ? pad_ff.pull_dn :
      (avs_address == `PCI_IDX_PADCTL)  ? {master_ff, 15'h0000} :
      (avs_address == `PCI_IDX_SUMMARY) ? {15'h0000, summary} :
      (avs_address == `PCI_IDX_IRQSTAT) ? {12'h000, ist_ff, 3'h0} :
      (avs_address == `PCI_IDX_IRQEN)   ? {12'h000, ien_ff, 3'h0} :
      `PCI_RST_ZERO;

   // Bus sequencer: one wait cycle, then a one-cycle answer
   always_comb begin
      nxt_state = state_ff;
      nxt_wait  = wait_ff;
      nxt_rdata = rdata_ff;
      case (state_ff)
         pci_pkg::PCI_IDLE: begin
            if (req) begin
               nxt_state = pci_pkg::PCI_ACK;
               nxt_wait  = 1'b0;
               nxt_rdata = avs_read ? {16'h0000, rd16} : 32'h0000_0000;
            end
         end
         pci_pkg::PCI_ACK: begin
            nxt_state = pci_pkg::PCI_IDLE;
            nxt_wait  = 1'b1;
         end
         default: begin
            nxt_state = pci_pkg::PCI_IDLE;
            nxt_wait  = 1'b1;
         end
      endcase
   end

   // Bus state; ce low freezes the answer in place
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= pci_pkg::PCI_IDLE;
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else if (ce) begin
         state_ff <= nxt_state;
         wait_ff  <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end

   // Control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         dir_ff    <= `PCI_RST_DIR;
         rise_ff   <= `PCI_RST_ZERO;
         fall_ff   <= `PCI_RST_ZERO;
         master_ff <= 1'b0;
         ien_ff    <= 1'b0;
         pad_ff    <= {~`PCI_RST_DIR, `PCI_RST_ZERO, `PCI_RST_ZERO,
                       `PCI_RST_ZERO};
      end else if (ce) begin
         dir_ff    <= nxt_dir;
         rise_ff   <= nxt_rise;
         fall_ff   <= nxt_fall;
         master_ff <= nxt_master;
         ien_ff    <= nxt_ien;
         pad_ff    <= nxt_pad;
      end
   end

   // Change detection state; prev starts at zero but takes the pin level
   // on the first enabled edge, before any rise enable can be written
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_ff <= `PCI_RST_ZERO;
         flag_ff <= `PCI_RST_ZERO;
         ist_ff  <= 1'b0;
         irq_ff  <= 1'b0;
      end else if (ce) begin
         prev_ff <= pin_in;
         flag_ff <= nxt_flag;
         ist_ff  <= nxt_ist;
         irq_ff  <= nxt_irq;
      end
   end

   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign pad_ctl         = pad_ff;
   assign irq             = irq_ff;

   // Checks
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_req_idle;
      ce && req && state_ff == pci_pkg::PCI_IDLE;
   endsequence
   sequence s_answer;
      !wait_ff ##1 wait_ff;
   endsequence

   a_bus_answer: assert property (s_req_idle |=> s_answer)
      else $error("bus answer not one cycle after request");

   a_rise_flags: assert property (
      (ce && gate_w) |=> ((flag_ff & $past(rise_hit)) == $past(rise_hit)))
      else $error("rising edge did not set flag");

   a_fall_flags: assert property (
      (ce && gate_w) |=> ((flag_ff & $past(fall_hit)) == $past(fall_hit)))
      else $error("falling edge did not set flag");

   a_gate_blocks: assert property (
      (ce && !gate_w && !hit_flg) |=> (flag_ff == $past(flag_ff)))
      else $error("flag changed while detection gated");

   a_flag_sticky: assert property (
      (ce && !hit_flg) |=> ((flag_ff & $past(flag_ff)) == $past(flag_ff)))
      else $error("flag dropped without a clearing write");

   a_clear_race: assert property (
      (ce && hit_flg && gate_w) |=> ((flag_ff & $past(evt)) == $past(evt)))
      else $error("edge lost during flag clear");

   a_summary_read: assert property (
      (s_req_idle and (avs_read && avs_address == `PCI_IDX_SUMMARY))
      |=> (avs_readdata[`PCI_BIT_SUMMARY] == $past(summary)))
      else $error("summary read does not follow flags");

   a_level_live: assert property (
      (s_req_idle and (avs_read && avs_address == `PCI_IDX_LEVEL))
      |=> (avs_readdata[15:0] == $past(pin_in)))
      else $error("level read is not the pin level");

   a_dir_oe: assert property (
      pad_ctl.oe == ~dir_ff)
      else $error("output enable does not follow direction");

   a_irq_raise: assert property (
      (ce && |flag_ff && master_ff && ien_ff && !hit_ien) |=> irq)
      else $error("interrupt not raised for set flag");

   a_flag_set: assert property (
      (ce && |evt) |=> ((flag_ff & $past(evt)) == $past(evt)))
      else $error("enabled edge did not set flag");

   a_both_edges: assert property (
      (ce && gate_w && |both_hit)
      |=> ((flag_ff & $past(both_hit)) == $past(both_hit)))
      else $error("edge on dual-enabled pin not recorded");

   a_edges_off: assert property (
      (ce && !hit_flg && rise_ff == 16'h0000 && fall_ff == 16'h0000)
      |=> (flag_ff == $past(flag_ff)))
      else $error("flag set with no edge enabled");

   a_irq_match: assert property (
      irq == (ist_ff && ien_ff))
      else $error("interrupt output not status and enable");

   a_ist_sticky: assert property (
      (ce && ist_ff && !hit_clr) |=> ist_ff)
      else $error("interrupt status dropped without clear");

   a_ist_clear: assert property (
      (ce && hit_clr && wmask[`PCI_BIT_GLOBAL] && wd[`PCI_BIT_GLOBAL]
       && !ist_set) |=> !ist_ff)
      else $error("interrupt status not cleared by write");

   a_pull_apart: assert property (
      (ce && hit_pu) |=> (pad_ctl.pull_dn == $past(pad_ctl.pull_dn)))
      else $error("pull-up write moved pull-down");

   a_out_hold: assert property (
      (ce && !hit_out) |=> (pad_ctl.out == $past(pad_ctl.out)))
      else $error("output latch changed without write");

   a_freeze_state: assert property (
      !ce |=> (flag_ff == $past(flag_ff) && irq == $past(irq)))
      else $error("state moved while clock enable low");

   a_wait_idle: assert property (
      (ce && state_ff == pci_pkg::PCI_IDLE && !req) |=> wait_ff)
      else $error("waitrequest low with no request");

   a_write_rdata: assert property (
      (s_req_idle and avs_write) |=> (avs_readdata == 32'h0000_0000))
      else $error("read data not zero after write");

endmodule
`default_nettype wire

// ---- pci_pins.sv ----
`timescale 1ns/10ps
`default_nettype none
// Far side of the port: pushbuttons on the pins, seen through the pads
module pci_pins (
   input  wire logic              clk,
   input  wire pci_pkg::pci_pad_t pad,
   input  wire logic [15:0]       btn_on,
   input  wire logic [15:0]       btn_val,
   output logic      [15:0]       pin_lvl
);
   logic [15:0] last_ff;

   // Live pin level
   // Pad drive wins, then a pressed button, then the weak pulls;
   // a floating pin toggles so no settled value is faked
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         pin_lvl[i] = pad.oe[i] ? pad.out[i] :
                      btn_on[i] ? btn_val[i] :
                      pad.pull_up[i] ? 1'b1 :
                      pad.pull_dn[i] ? 1'b0 : ~last_ff[i];
      end
   end

   // Last level, for the floating toggle
   always_ff @(posedge clk) begin
      last_ff <= pin_lvl;
   end
endmodule
`default_nettype wire

// ---- pci_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pci_map.svh"
module tb;
   logic              clk, rst, ce, avs_read, avs_write, avs_waitrequest;
   logic              irq;
   logic [3:0]        avs_address, avs_byteenable;
   logic [31:0]       avs_writedata, avs_readdata;
   logic [15:0]       pin_in, btn_on, btn_val, rd;
   pci_pkg::pci_pad_t pad_ctl;
   int                n_mismatch, comparisons;

   pci_port dut_u (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pin_in(pin_in), .pad_ctl(pad_ctl), .irq(irq));
   pci_pins pins_u (.clk(clk), .pad(pad_ctl), .btn_on(btn_on),
      .btn_val(btn_val), .pin_lvl(pin_in));

   task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask

   // Waits out the bus; only the bench limit ends a stuck access
   task automatic bus(logic w, logic [3:0] a, logic [15:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= w;
      avs_read <= ~w;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[15:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rdc(logic [3:0] a, logic [15:0] exp, string nm);
      bus(1'b0, a, 16'h0000);
      chk(nm, rd, exp);
   endtask

   // Clear flags the safe way: zero only what was seen set
   // only called between pin events
   task automatic clr_all();
      bus(1'b0, `PCI_IDX_FLAG, 16'h0000);
      bus(1'b1, `PCI_IDX_FLAG, 16'hFFFF ^ rd);
      bus(1'b1, `PCI_IDX_IRQCLR, 16'h0008);
   endtask

   task automatic t_reset();
      rdc(`PCI_IDX_DIR, 16'hFFFF, "dir");
      chk("oe", pad_ctl.oe, 16'h0000);
      chk("irq", {15'h0000, irq}, 16'h0000);
      rdc(4'hF, 16'h0000, "unmapped");
      $display("reset test done");
   endtask

   task automatic t_pads();
      bus(1'b1, `PCI_IDX_OUT, 16'h00A5);
      bus(1'b1, `PCI_IDX_DIR, 16'hFF00);
      @(posedge clk);
      chk("oe", pad_ctl.oe, 16'h00FF);
      rdc(`PCI_IDX_LEVEL, 16'h00A5, "level");
      // pulls only once every pin is an input
      bus(1'b1, `PCI_IDX_DIR, 16'hFFFF);
      bus(1'b1, `PCI_IDX_PULLUP, 16'h0F00);
      bus(1'b1, `PCI_IDX_PULLDN, 16'h00F0);
      @(posedge clk);
      chk("pull_up", pad_ctl.pull_up, 16'h0F00);
      chk("pull_dn", pad_ctl.pull_dn, 16'h00F0);
      btn_on <= 16'hFEEF;
      rdc(`PCI_IDX_LEVEL, 16'h0100, "pulled");
      btn_on <= 16'hFFFF;
      $display("pad test done");
   endtask

   task automatic t_edges();
      bus(1'b1, `PCI_IDX_IRQEN, 16'h0008);
      bus(1'b1, `PCI_IDX_PADCTL, 16'h8000);
      bus(1'b1, `PCI_IDX_RISE, 16'h0005);
      bus(1'b1, `PCI_IDX_FALL, 16'h0006);
      btn_val <= 16'h0001;
      repeat (4) @(posedge clk);
      rdc(`PCI_IDX_FLAG, 16'h0001, "rise flag");
      rdc(`PCI_IDX_SUMMARY, 16'h0001, "summary");
      chk("irq", {15'h0000, irq}, 16'h0001);
      clr_all();
      rdc(`PCI_IDX_SUMMARY, 16'h0000, "summary");
      chk("irq", {15'h0000, irq}, 16'h0000);
      btn_val <= 16'h0004;
      repeat (4) @(posedge clk);
      rdc(`PCI_IDX_FLAG, 16'h0004, "both rise");
      clr_all();
      btn_val <= 16'h0000;
      repeat (4) @(posedge clk);
      rdc(`PCI_IDX_FLAG, 16'h0004, "fall flag");
      bus(1'b1, `PCI_IDX_FLAG, 16'hFFFF);
      rdc(`PCI_IDX_FLAG, 16'h0004, "one keeps");
      btn_val <= 16'h0001;
      repeat (4) @(posedge clk);
      rdc(`PCI_IDX_FLAG, 16'h0004, "status gate");
      rdc(`PCI_IDX_IRQSTAT, 16'h0008, "irq status");
      rdc(`PCI_IDX_IRQEN, 16'h0008, "irq enable");
      clr_all();
      bus(1'b1, `PCI_IDX_PADCTL, 16'h0000);
      btn_val <= 16'h0005;
      repeat (4) @(posedge clk);
      rdc(`PCI_IDX_FLAG, 16'h0000, "master gate");
      $display("edge test done");
   endtask

   // Pin change while the clock enable is low, seen on wake-up
   task automatic t_sleep();
      bus(1'b1, `PCI_IDX_PADCTL, 16'h8000);
      rdc(`PCI_IDX_PADCTL, 16'h8000, "master");
      ce <= 1'b0;
      btn_val <= 16'h0001;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(`PCI_IDX_FLAG, 16'h0004, "sleep fall");
      rdc(`PCI_IDX_IRQSTAT, 16'h0008, "sleep status");
      chk("irq", {15'h0000, irq}, 16'h0001);
      $display("sleep test done");
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Guards against a hung handshake
   initial begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end

   // Main sequence; byte lanes stay on throughout, clock enable drops only in t_sleep
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      btn_on = 16'hFFFF;
      btn_val = 16'h0000;
      n_mismatch = 0;
      comparisons = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_pads();
      t_edges();
      t_sleep();
      give_verdict();
   end
endmodule
`default_nettype wire
